// >>> rtl/dit_regs.vh
// register offsets, field positions, reset values and clock-select codes
// for the dual interval timer block; definitions only, no logic.
// assumes an 8-bit register port whose address matches these offsets.
`ifndef DIT_REGS_VH
`define DIT_REGS_VH

`define DIT_ADDR_B_CTRL    8'hba
`define DIT_ADDR_A_CTRL    8'hbb
`define DIT_ADDR_A_REF     8'hbc
`define DIT_ADDR_B_REF     8'hbd
`define DIT_ADDR_A_CNT     8'hbe
`define DIT_ADDR_B_CNT     8'hbf
`define DIT_ADDR_PEND      8'hc0

`define DIT_CTRL_RESET     8'h00
`define DIT_REF_RESET      8'hff
`define DIT_BIT_COMBINE    7
`define DIT_BIT_CLEAR      3
`define DIT_BIT_INTERVAL   2
`define DIT_BIT_IRQ_EN     1
`define DIT_SEL_HI         6
`define DIT_SEL_LO         4
`define DIT_PEND_A         0
`define DIT_PEND_B         1

`define DIT_SEL_DIV512     3'h0
`define DIT_SEL_DIV256     3'h1
`define DIT_SEL_DIV64      3'h2
`define DIT_SEL_DIV8       3'h3
`define DIT_SEL_DIV1       3'h4
`define DIT_SEL_SUB        3'h5

`endif

// >>> rtl/dit_timers.v
// dual 8-bit interval timers with optional 16-bit joined mode.
// assumes all inputs synchronous to clock; register port is a simple
// one-cycle write strobe, read data registered one cycle after address.
`timescale 1ns/100ps
`include "dit_regs.vh"

module dit_timers (
  input  wire       clock,
  input  wire       sys_rst,
  input  wire [7:0] regAddr,
  input  wire       regWrEn,
  input  wire [7:0] regWrData,
  output reg  [7:0] regRdData,
  input  wire       subsystemClock,
  input  wire       externalTimerClock,
  output reg        timerAMatchPin,
  output reg        timerAMatchIrq,
  output reg        timerBMatchIrq
);

  // block outline
  // - one free 9-bit prescaler feeds both timers; taps give /512 down to /1
  // - subsystem and external clock inputs are edge detected, never used as clocks
  // - each timer: 8-bit up counter, 8-bit reference, equality compare
  // - a match clears the counter and counting resumes from zero
  // - a match sets the pending bit whether or not the interrupt is enabled
  // - software clears pending by writing 0; writing 1 leaves it alone
  // - control bit 3 is a strobe: it clears the counter (in joined mode A's clears both bytes, B's does nothing) and is not stored
  // - joined mode (control A bit 7) chains B above A as one 16-bit timer
  // limitations
  // - the prescaler is not cleared by the counter clear, so the first
  //   interval after a start may be short by up to one prescaler period
  // - a clock input pulse must last at least one clock to be seen
  // - pulses faster than half the system clock are lost, not counted
  // trade-off: one shared prescaler costs less than one per timer, at the
  // price of the phase freedom of each timer's first tick

  reg  [7:0] timerAControl_q;
  reg  [7:0] timerBControl_q;
  reg  [7:0] timerAReference_q;
  reg  [7:0] timerBReference_q;
  reg  [7:0] timerACounter_q;
  reg  [7:0] timerBCounter_q;
  reg  [1:0] irqPending_q;
  reg  [8:0] prescale_q;
  reg        subLast_q;
  reg        extLast_q;

  wire       subEdge = subsystemClock & ~subLast_q;
  wire       extEdge = externalTimerClock & ~extLast_q;
  wire       combined = timerAControl_q[`DIT_BIT_COMBINE];

  // one tick per selected clock edge; unknown codes fall to the pin (A) or sub (B)
  // the taps are and-reductions of the low prescaler bits, so every division
  // ticks exactly once per period and all divisions stay in phase
  // used twice, once per timer; B passes the subsystem edge as its fallback
  // so that timer B can never reach the external pin
  function tickSel;
    input [2:0] sel;
    input [8:0] pre;
    input       sub;
    input       alt;
    begin
      case (sel)
        `DIT_SEL_DIV512: tickSel = &pre[8:0];
        `DIT_SEL_DIV256: tickSel = &pre[7:0];
        `DIT_SEL_DIV64:  tickSel = &pre[5:0];
        `DIT_SEL_DIV8:   tickSel = &pre[2:0];
        `DIT_SEL_DIV1:   tickSel = 1'b1;
        `DIT_SEL_SUB:    tickSel = sub;
        default:         tickSel = alt;
      endcase
    end
  endfunction

  wire tickA = tickSel(timerAControl_q[`DIT_SEL_HI:`DIT_SEL_LO], prescale_q, subEdge, extEdge);
  wire tickB = tickSel(timerBControl_q[`DIT_SEL_HI:`DIT_SEL_LO], prescale_q, subEdge, subEdge);

  wire wrACtrl = regWrEn & (regAddr == `DIT_ADDR_A_CTRL);
  wire wrBCtrl = regWrEn & (regAddr == `DIT_ADDR_B_CTRL);
  wire clrA    = wrACtrl & regWrData[`DIT_BIT_CLEAR];
  wire clrB    = wrBCtrl & regWrData[`DIT_BIT_CLEAR];

  // joined mode runs on timer A's enable and clock only
  wire runA  = timerAControl_q[`DIT_BIT_INTERVAL] & tickA;
  wire runB  = timerBControl_q[`DIT_BIT_INTERVAL] & tickB;
  wire matchA8  = timerACounter_q == timerAReference_q;
  wire matchB8  = timerBCounter_q == timerBReference_q;
  wire match16  = matchA8 & matchB8;
  wire hitA = combined ? (runA & match16) : (runA & matchA8);
  wire hitB = ~combined & runB & matchB8;

  // free-running prescaler shared by both timers, plus edge memories
  always @(posedge clock) begin
    if (sys_rst) begin
      prescale_q <= 9'h000;
      subLast_q  <= 1'b0;
      extLast_q  <= 1'b0;
    end else begin
      prescale_q <= prescale_q + 9'h001;
      subLast_q  <= subsystemClock;
      extLast_q  <= externalTimerClock;
    end
  end

  // control and reference registers; clear bit is a strobe, never stored
  always @(posedge clock) begin
    if (sys_rst) begin
      timerAControl_q   <= `DIT_CTRL_RESET;
      timerBControl_q   <= `DIT_CTRL_RESET;
      timerAReference_q <= `DIT_REF_RESET;
      timerBReference_q <= `DIT_REF_RESET;
    end else begin
      if (wrACtrl)
        timerAControl_q <= regWrData & 8'hf7;
      if (wrBCtrl)
        timerBControl_q <= regWrData & 8'h77;
      if (regWrEn && regAddr == `DIT_ADDR_A_REF)
        timerAReference_q <= regWrData;
      if (regWrEn && regAddr == `DIT_ADDR_B_REF)
        timerBReference_q <= regWrData;
    end
  end

  // counters: clear wins over counting so a started interval counts from zero
  // a match is only taken on a tick, so the period is (reference + 1) ticks
  // joined mode: A is the low byte and carries into B when it rolls over;
  // the match needs both bytes equal, and both bytes clear together
  // a reference of zero gives a match on every tick
  // stopping the timer keeps the count; software restarts it with a clear
  // writing the reference while running takes effect on the next compare,
  // so a reference below the count runs on past the wrap before matching
  always @(posedge clock) begin
    if (sys_rst) begin
      timerACounter_q <= 8'h00;
      timerBCounter_q <= 8'h00;
    end else if (combined) begin
      if (clrA || hitA) begin
        timerACounter_q <= 8'h00;
        timerBCounter_q <= 8'h00;
      end else if (runA) begin
        timerACounter_q <= timerACounter_q + 8'h01;
        if (&timerACounter_q)
          timerBCounter_q <= timerBCounter_q + 8'h01; // carry into high byte
      end
    end else begin
      if (clrA || hitA)
        timerACounter_q <= 8'h00;
      else if (runA)
        timerACounter_q <= timerACounter_q + 8'h01;
      if (clrB || hitB)
        timerBCounter_q <= 8'h00;
      else if (runB)
        timerBCounter_q <= timerBCounter_q + 8'h01;
    end
  end

  // pending bits: a write of 0 clears, a same-cycle match still sets
  // set wins so a match that lands on a service write is never lost;
  // software that clears a bit already serviced cannot hide a new event
  // in joined mode only bit 0 is ever set by a match
  wire       wrPend = regWrEn & (regAddr == `DIT_ADDR_PEND);
  wire [1:0] pendKeep = wrPend ? (irqPending_q & regWrData[1:0]) : irqPending_q;
  wire [1:0] pendNext = pendKeep | {hitB, hitA};

  always @(posedge clock) begin
    if (sys_rst)
      irqPending_q <= 2'b00;
    else
      irqPending_q <= pendNext;
  end

  // outputs from flops; irq only when enabled and not in joined mode for B
  // irq is a level built from the next pending value, so it rises on the
  // same edge as the pending bit; a control change shows one edge later
  // the pin toggles rather than pulses so slow observers see every match
  always @(posedge clock) begin
    if (sys_rst) begin
      timerAMatchPin <= 1'b0;
      timerAMatchIrq <= 1'b0;
      timerBMatchIrq <= 1'b0;
    end else begin
      if (hitA)
        timerAMatchPin <= ~timerAMatchPin;
      timerAMatchIrq <= pendNext[`DIT_PEND_A] & timerAControl_q[`DIT_BIT_IRQ_EN]
                        & timerAControl_q[`DIT_BIT_INTERVAL];
      timerBMatchIrq <= pendNext[`DIT_PEND_B] & timerBControl_q[`DIT_BIT_IRQ_EN]
                        & timerBControl_q[`DIT_BIT_INTERVAL] & ~combined;
    end
  end

  // registered read mux; unmapped addresses read zero
  // read data lags the address by one edge; the counters are read only
  // and a write to their offsets is ignored
  always @(posedge clock) begin
    if (sys_rst)
      regRdData <= 8'h00;
    else begin
      case (regAddr)
        `DIT_ADDR_A_CTRL: regRdData <= timerAControl_q;
        `DIT_ADDR_B_CTRL: regRdData <= timerBControl_q;
        `DIT_ADDR_A_REF:  regRdData <= timerAReference_q;
        `DIT_ADDR_B_REF:  regRdData <= timerBReference_q;
        `DIT_ADDR_A_CNT:  regRdData <= timerACounter_q;
        `DIT_ADDR_B_CNT:  regRdData <= timerBCounter_q;
        `DIT_ADDR_PEND:   regRdData <= {6'h00, irqPending_q};
        default:          regRdData <= 8'h00;
      endcase
    end
  end

endmodule // dit_timers

// >>> testbench/dit_timers_sva.sv
// port checker for the dual interval timers
// assumes it is bound to dit_timers from the bench top file
`timescale 1ns/100ps
module dit_timers_sva (
  input wire       clock,
  input wire       sys_rst,
  input wire [7:0] regAddr,
  input wire       regWrEn,
  input wire [7:0] regWrData,
  input wire [7:0] regRdData,
  input wire       subsystemClock,
  input wire       externalTimerClock,
  input wire       timerAMatchPin,
  input wire       timerAMatchIrq,
  input wire       timerBMatchIrq
);
  reg [7:0] aCtl_q;
  reg [7:0] bCtl_q;
  // shadow of both controls, taken from the write strobe
  always @(posedge clock) begin
    if (sys_rst) begin
      aCtl_q <= 8'h00;
      bCtl_q <= 8'h00;
    end else if (regWrEn && regAddr == 8'hbb) begin
      aCtl_q <= regWrData;
    end else if (regWrEn && regAddr == 8'hba) begin
      bCtl_q <= regWrData;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  rst_outs_a: assert property ($fell(sys_rst) |-> !timerAMatchPin && !timerAMatchIrq && !timerBMatchIrq)
    else $error("outputs not low after reset");
  a_ctl_rd_a: assert property (regWrEn && regAddr == 8'hbb ##1 !regWrEn && regAddr == 8'hbb
    |=> regRdData == ($past(regWrData, 2) & 8'hf7)) else $error("control a readback wrong");
  b_ctl_rd_a: assert property (regWrEn && regAddr == 8'hba ##1 !regWrEn && regAddr == 8'hba
    |=> regRdData == ($past(regWrData, 2) & 8'h77)) else $error("control b readback wrong");
  unmapped_rd_a: assert property (regAddr == 8'h00 |=> regRdData == 8'h00) else $error("unmapped read not zero");
  a_irq_gate_a: assert property (timerAMatchIrq |-> $past(aCtl_q[2:1]) == 2'b11) else $error("irq a while disabled");
  b_irq_gate_a: assert property (timerBMatchIrq |-> !$past(aCtl_q[7]) && $past(bCtl_q[2:1]) == 2'b11)
    else $error("irq b while disabled");
  pin_enable_a: assert property ($changed(timerAMatchPin) |-> $past(aCtl_q[2])) else $error("pin moved while stopped");
  irq_fall_a: assert property ($fell(timerAMatchIrq) |-> $past(regWrEn) || $past(regWrEn, 2))
    else $error("irq a dropped by itself");
endmodule // dit_timers_sva

// >>> testbench/tb_dit_timers.sv
// self-checking bench for the dual interval timers
// assumes rtl/ on the include path; inputs change on the falling edge
`timescale 1ns/100ps
module tb_dit_timers;
  reg        clock = 1'b0;
  reg        sys_rst = 1'b1;
  reg  [7:0] regAddr = 8'h00;
  reg        regWrEn = 1'b0;
  reg  [7:0] regWrData = 8'h00;
  reg        subsystemClock = 1'b0;
  reg        externalTimerClock = 1'b0;
  wire [7:0] regRdData;
  wire       timerAMatchPin;
  wire       timerAMatchIrq;
  wire       timerBMatchIrq;
  integer    num_errors = 0;
  integer    comparisons = 0;
  reg  [7:0] d;
  integer    i;
  integer    n;
  dit_timers dut (.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdData(regRdData), .subsystemClock(subsystemClock), .externalTimerClock(externalTimerClock),
    .timerAMatchPin(timerAMatchPin), .timerAMatchIrq(timerAMatchIrq), .timerBMatchIrq(timerBMatchIrq));
  always #4 clock = ~clock;
  task finish_test;
    begin
      $display("checks %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [95:0] what, input [15:0] exp, input [15:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // one-cycle strobe; held through the sampling edge
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(negedge clock);
      regAddr = a;
      regWrData = v;
      regWrEn = 1'b1;
      @(negedge clock);
      regWrEn = 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(negedge clock);
      regAddr = a;
      repeat (2) @(negedge clock);
      d = regRdData;
    end
  endtask
  task pulse(input sub);
    begin
      if (sub) subsystemClock = 1'b1;
      else externalTimerClock = 1'b1;
      repeat (2) @(negedge clock);
      subsystemClock = 1'b0;
      externalTimerClock = 1'b0;
      repeat (2) @(negedge clock);
    end
  endtask
  task t_reset;
    begin
      rd(8'hbb); chk("ctl a", 16'h0, d);
      rd(8'hba); chk("ctl b", 16'h0, d);
      rd(8'h00); chk("unmapped", 16'h0, d);
    end
  endtask
  // second interval only: the free prescaler skews the first one
  task t_period;
    begin
      wr(8'hbc, 8'h01);
      for (i = 0; i < 5; i = i + 1) begin
        wr(8'hbb, {1'b0, i[2:0], 4'he});
        repeat (2) begin
          d[0] = timerAMatchPin;
          n = 0;
          while (timerAMatchPin === d[0] && n < 3000) begin
            @(negedge clock);
            n = n + 1;
          end
        end
        chk("period", 16'h2 << (i == 0 ? 9 : i == 1 ? 8 : i == 2 ? 6 : i == 3 ? 3 : 0), n[15:0]);
        chk("irq a", 16'h1, timerAMatchIrq);
      end
      wr(8'hbb, 8'h40);
      wr(8'hc0, 8'h03); rd(8'hc0); chk("pend keep", 16'h1, d);
      wr(8'hc0, 8'h02); rd(8'hc0); chk("pend clr", 16'h0, d);
    end
  endtask
  task t_clocks;
    begin
      wr(8'hbc, 8'hff);
      for (i = 5; i < 7; i = i + 1) begin
        wr(8'hbb, {1'b0, i[2:0], 4'hc});
        repeat (3) pulse(1'b1);
        repeat (2) pulse(1'b0);
        rd(8'hbe); chk("count a", i == 5 ? 16'h3 : 16'h2, d);
      end
      wr(8'hbb, 8'h68); pulse(1'b0);
      rd(8'hbe); chk("clear a", 16'h0, d);
    end
  endtask
  task t_timer_b;
    begin
      wr(8'hbd, 8'h02); wr(8'hba, 8'h44);
      repeat (4) @(negedge clock);
      rd(8'hc0); chk("pend b", 16'h2, d);
      chk("irq b off", 16'h0, timerBMatchIrq);
      wr(8'hba, 8'h46); @(negedge clock); chk("irq b", 16'h1, timerBMatchIrq);
      wr(8'hba, 8'h88); rd(8'hbf); chk("clear b", 16'h0, d);
    end
  endtask
  // joined 16-bit: ref 0101 at /1 gives 258 cycles between toggles
  task t_combined;
    begin
      wr(8'hba, 8'h00); wr(8'hc0, 8'h00);
      wr(8'hbc, 8'h01); wr(8'hbd, 8'h01);
      wr(8'hbb, 8'hce);
      repeat (2) begin
        d[0] = timerAMatchPin;
        n = 0;
        while (timerAMatchPin === d[0] && n < 3000) begin
          @(negedge clock);
          n = n + 1;
        end
      end
      chk("period 16", 16'd258, n[15:0]);
      chk("irq b comb", 16'h0, timerBMatchIrq);
      wr(8'hbb, 8'h80);
      rd(8'hc0); chk("pend comb", 16'h1, d);
      wr(8'hbb, 8'h00);
    end
  endtask
  initial begin
    repeat (20) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    t_reset;
    t_period;
    t_clocks;
    t_timer_b;
    t_combined;
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge clock);
    num_errors = num_errors + 1;
    finish_test;
  end
endmodule // tb_dit_timers
bind dit_timers dit_timers_sva u_sva (.*);
